// *** hw/mdcr_pkg.sv ***
// Package for the motor driver configuration register group (registers 4 to 9)
package mdcr_pkg;
    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int FRAME_W = 16;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 11;
    localparam int WR_BIT = 10;
    localparam int DATA_HI = 9;
    localparam int DATA_LO = 1;
    localparam int DATA_W = 9;
    localparam logic [4:0] BIT_CNT_FULL = 5'h10;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_BEMF_DETECT = 5'h04;
    localparam logic [4:0] ADDR_WD_MIN = 5'h05;
    localparam logic [4:0] ADDR_WD_WINDOW = 5'h06;
    localparam logic [4:0] ADDR_SENSE_AMP = 5'h07;
    localparam logic [4:0] ADDR_TURN_ON = 5'h08;
    localparam logic [4:0] ADDR_TURN_OFF = 5'h09;

    // ------------------------------------------------------------------
    // Writable data bits per register (frame bits 9..1)
    // ------------------------------------------------------------------
    localparam logic [8:0] MASK_BEMF_DETECT = 9'h07f;
    localparam logic [8:0] MASK_WD_MIN = 9'h01f;
    localparam logic [8:0] MASK_WD_WINDOW = 9'h1ff;
    localparam logic [8:0] MASK_SENSE_AMP = 9'h1ff;
    localparam logic [8:0] MASK_GATE = 9'h0ff;

    // ------------------------------------------------------------------
    // Field positions inside the 9-bit data word
    // ------------------------------------------------------------------
    localparam int POS_SELECTOR = 4;
    localparam int POS_FILTER = 0;
    localparam int POS_FAIL_COUNT = 5;
    localparam int POS_WINDOW = 0;
    localparam int POS_MIN_TIME = 0;
    localparam int POS_CALIBRATE = 8;
    localparam int POS_OFFSET = 4;
    localparam int POS_OFFSET_OUT = 3;
    localparam int POS_GAIN = 0;
    localparam int POS_FIRST = 4;
    localparam int POS_SECOND = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [8:0] RST_BEMF_DETECT = 9'h001;
    localparam logic [8:0] RST_WD_MIN = 9'h000;
    localparam logic [8:0] RST_WD_WINDOW = 9'h000;
    localparam logic [8:0] RST_SENSE_AMP = 9'h0c2;
    localparam logic [8:0] RST_TURN_ON = 9'h000;
    localparam logic [8:0] RST_TURN_OFF = 9'h000;

    // ------------------------------------------------------------------
    // Scaling of decoded settings
    // ------------------------------------------------------------------
    localparam logic [7:0] WD_MIN_BASE_MS = 8'h01;
    localparam logic [7:0] WD_MIN_STEP_MS = 8'h02;
    localparam logic [8:0] WD_WIN_BASE_MS = 9'h00a;
    localparam logic [8:0] WD_WIN_STEP_MS = 9'h00a;
    localparam logic [16:0] TURN_ON_STEP_UA = 17'h0157c;
    localparam logic [16:0] TURN_OFF_STEP_UA = 17'h014b4;

    // Selector output choices
    typedef enum logic [1:0] {
        MDCR_SEL_SPEED,
        MDCR_SEL_PHASE_A,
        MDCR_SEL_PHASE_B,
        MDCR_SEL_PHASE_C
    } mdcr_sel_t;

    // Comparator inputs from the analog side
    typedef struct packed {
        logic speed_pulse_signal;
        logic phase_a;
        logic phase_b;
        logic phase_c;
    } mdcr_cmp_t;

    // Decoded settings handed to the analog and watchdog blocks
    typedef struct packed {
        logic [2:0] bemf_pin_selector;
        logic [3:0] windmill_filter_time;
        logic [15:0] filter_us;
        logic [7:0] wd_min_ms;
        logic [3:0] watchdog_fail_count;
        logic wd_counter_enable;
        logic [8:0] wd_window_ms;
        logic [3:0] amp_offset_level;
        logic [11:0] amp_offset_mv;
        logic amp_offset_out;
        logic [2:0] amp_gain_select;
        logic [5:0] amp_gain;
        logic [3:0] turn_on_current_first;
        logic [3:0] turn_on_current_second;
        logic [3:0] turn_off_current_first;
        logic [3:0] turn_off_current_second;
        logic [16:0] turn_on_first_ua;
        logic [16:0] turn_on_second_ua;
        logic [16:0] turn_off_first_ua;
        logic [16:0] turn_off_second_ua;
        logic [3:0] switch_mode;
    } mdcr_cfg_t;
endpackage

// *** hw/mdcr_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module mdcr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Asynchronous inputs
    input wire logic [W-1:0] async_in,
    // Filtered level
    output logic [W-1:0] level
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, level_reg;
    logic [W-1:0] level_next;

    // A change only counts once stages two and three agree
    always_comb begin
        level_next = level_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                level_next[i] = s2_reg[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            level_reg <= INIT;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule

// *** hw/mdcr_regs.sv ***
// Serial-frame configuration registers 4 to 9 of the motor gate driver
`timescale 1ns/1ps
module mdcr_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Serial interface pins
    input wire logic strobe_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    // Comparator inputs
    input wire mdcr_pkg::mdcr_cmp_t cmp_in,
    // Settings and events
    output logic bemf_pin_out,
    output logic calibrate_start,
    output logic frame_error,
    output mdcr_pkg::mdcr_cfg_t cfg
);
    import mdcr_pkg::*;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] filter_us_of(input logic [3:0] code);
        logic [15:0] t;
        t = 16'h0000;
        unique case (code)
            4'h0: t = 16'h0000;
            4'h1: t = 16'h00c8;
            4'h2: t = 16'h0190;
            4'h3: t = 16'h0258;
            4'h4: t = 16'h0320;
            4'h5: t = 16'h03e8;
            4'h6: t = 16'h07d0;
            4'h7: t = 16'h0fa0;
            4'h8: t = 16'h1388;
            4'h9: t = 16'h1770;
            4'ha: t = 16'h2710;
            4'hb: t = 16'h2ee0;
            4'hc: t = 16'h36b0;
            4'hd: t = 16'h3e80;
            4'he: t = 16'h4650;
            4'hf: t = 16'h4e20;
        endcase
        return t;
    endfunction

    function automatic logic [11:0] offset_mv_of(input logic [3:0] code);
        logic [11:0] v;
        v = 12'h000;
        unique case (code)
            4'h0, 4'h1: v = 12'h000;
            4'h2, 4'h3: v = 12'h064;
            4'h4: v = 12'h0c8;
            4'h5: v = 12'h12c;
            4'h6: v = 12'h190;
            4'h7: v = 12'h1f4;
            4'h8: v = 12'h2ee;
            4'h9: v = 12'h3e8;
            4'ha: v = 12'h4e2;
            4'hb: v = 12'h5dc;
            4'hc: v = 12'h672;
            4'hd: v = 12'h7d0;
            4'he: v = 12'h8ca;
            4'hf: v = 12'h9c4;
        endcase
        return v;
    endfunction

    function automatic logic [5:0] gain_of(input logic [2:0] code);
        logic [5:0] g;
        g = (code == 3'h7) ? 6'h32 : 6'(6'h0a + 6'(code) * 6'h05);
        return g;
    endfunction

    function automatic logic [16:0] current_ua(input logic [3:0] n, input logic [16:0] step);
        logic [16:0] c;
        c = 17'(step * 17'(n));
        return c;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [6:0] pins;
    logic strn_s, sck_s, sdi_s;
    mdcr_cmp_t cmp_s;

    mdcr_sync #(.W(7), .INIT(7'h40)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .async_in({strobe_n, sck, sdi, cmp_in}),
        .level(pins)
    );
    assign strn_s = pins[6];
    assign sck_s = pins[5];
    assign sdi_s = pins[4];
    assign cmp_s = pins[3:0];

    // ------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------
    logic strn_prev_reg, sck_prev_reg, strn_prev_next, sck_prev_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [15:0] shin_reg, shin_next, shout_reg, shout_next;
    logic [4:0] rd_addr_reg, rd_addr_next;
    logic sdo_reg, sdo_next, sdo_oe_reg, sdo_oe_next;
    logic ferr_reg, ferr_next;
    logic wr_en;
    logic [4:0] fr_addr;
    logic [8:0] fr_data;
    logic [8:0] r4_reg, r5_reg, r6_reg, r7_reg, r8_reg, r9_reg;
    logic [8:0] r4_next, r5_next, r6_next, r7_next, r8_next, r9_next;
    logic [8:0] rd_data;
    logic [15:0] rd_frame;

    // Read data for the address of the last complete frame with odd parity
    always_comb begin
        unique case (rd_addr_reg)
            ADDR_BEMF_DETECT: rd_data = r4_reg;
            ADDR_WD_MIN: rd_data = r5_reg;
            ADDR_WD_WINDOW: rd_data = r6_reg;
            ADDR_SENSE_AMP: rd_data = r7_reg;
            ADDR_TURN_ON: rd_data = r8_reg;
            ADDR_TURN_OFF: rd_data = r9_reg;
            default: rd_data = 9'h000;
        endcase
        rd_frame = {rd_addr_reg, 1'b0, rd_data, 1'b0};
        rd_frame[0] = ~^rd_frame[15:1];
    end

    assign fr_addr = shin_reg[ADDR_HI:ADDR_LO];
    assign fr_data = shin_reg[DATA_HI:DATA_LO];

    always_comb begin
        strn_prev_next = strn_s;
        sck_prev_next = sck_s;
        bit_cnt_next = bit_cnt_reg;
        shin_next = shin_reg;
        shout_next = shout_reg;
        rd_addr_next = rd_addr_reg;
        sdo_next = sdo_reg;
        sdo_oe_next = ~strn_s;
        ferr_next = ferr_reg;
        wr_en = 1'b0;
        if (strn_prev_reg && !strn_s) begin
            // Frame opens: present the first read bit at once
            bit_cnt_next = 5'h00;
            shout_next = {rd_frame[14:0], 1'b0};
            sdo_next = rd_frame[15];
        end else if (!strn_s) begin
            if (!sck_prev_reg && sck_s && bit_cnt_reg != BIT_CNT_FULL) begin
                shin_next = {shin_reg[14:0], sdi_s};
                bit_cnt_next = 5'(bit_cnt_reg + 5'h01);
            end else if (sck_prev_reg && !sck_s) begin
                sdo_next = shout_reg[15];
                shout_next = {shout_reg[14:0], 1'b0};
            end
        end else if (!strn_prev_reg && strn_s) begin
            // Frame closes: commit only complete frames with odd parity
            if (bit_cnt_reg == BIT_CNT_FULL && ^shin_reg) begin
                ferr_next = 1'b0;
                rd_addr_next = fr_addr;
                wr_en = shin_reg[WR_BIT];
            end else begin
                ferr_next = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            strn_prev_reg <= 1'b1;
            sck_prev_reg <= 1'b0;
            bit_cnt_reg <= 5'h00;
            shin_reg <= 16'h0000;
            shout_reg <= 16'h0000;
            rd_addr_reg <= 5'h00;
            sdo_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
            ferr_reg <= 1'b0;
        end else begin
            strn_prev_reg <= strn_prev_next;
            sck_prev_reg <= sck_prev_next;
            bit_cnt_reg <= bit_cnt_next;
            shin_reg <= shin_next;
            shout_reg <= shout_next;
            rd_addr_reg <= rd_addr_next;
            sdo_reg <= sdo_next;
            sdo_oe_reg <= sdo_oe_next;
            ferr_reg <= ferr_next;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic cal_next, cal_reg;

    always_comb begin
        r4_next = r4_reg;
        r5_next = r5_reg;
        r6_next = r6_reg;
        r7_next = r7_reg;
        r8_next = r8_reg;
        r9_next = r9_reg;
        cal_next = 1'b0;
        if (wr_en) begin
            unique case (fr_addr)
                ADDR_BEMF_DETECT: r4_next = fr_data & MASK_BEMF_DETECT;
                ADDR_WD_MIN: r5_next = fr_data & MASK_WD_MIN;
                ADDR_WD_WINDOW: r6_next = fr_data & MASK_WD_WINDOW;
                ADDR_SENSE_AMP: begin
                    r7_next = fr_data & MASK_SENSE_AMP;
                    // Level or falling calibrate bit does nothing
                    cal_next = fr_data[POS_CALIBRATE] && !r7_reg[POS_CALIBRATE]
                        && !fr_data[POS_OFFSET_OUT];
                end
                ADDR_TURN_ON: r8_next = fr_data & MASK_GATE;
                ADDR_TURN_OFF: r9_next = fr_data & MASK_GATE;
                default: r4_next = r4_reg;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r4_reg <= RST_BEMF_DETECT;
            r5_reg <= RST_WD_MIN;
            r6_reg <= RST_WD_WINDOW;
            r7_reg <= RST_SENSE_AMP;
            r8_reg <= RST_TURN_ON;
            r9_reg <= RST_TURN_OFF;
            cal_reg <= 1'b0;
        end else begin
            r4_reg <= r4_next;
            r5_reg <= r5_next;
            r6_reg <= r6_next;
            r7_reg <= r7_next;
            r8_reg <= r8_next;
            r9_reg <= r9_next;
            cal_reg <= cal_next;
        end
    end

    // ------------------------------------------------------------------
    // Decoded settings and comparator selector
    // ------------------------------------------------------------------
    mdcr_cfg_t cfg_reg, cfg_next;
    logic bemf_reg, bemf_next;

    always_comb begin
        cfg_next.bemf_pin_selector = r4_reg[POS_SELECTOR +: 3];
        cfg_next.windmill_filter_time = r4_reg[POS_FILTER +: 4];
        cfg_next.filter_us = filter_us_of(r4_reg[POS_FILTER +: 4]);
        cfg_next.wd_min_ms = 8'(WD_MIN_BASE_MS + WD_MIN_STEP_MS * 8'(r5_reg[POS_MIN_TIME +: 5]));
        cfg_next.watchdog_fail_count = r6_reg[POS_FAIL_COUNT +: 4];
        cfg_next.wd_counter_enable = r6_reg[POS_FAIL_COUNT +: 4] != 4'h0;
        cfg_next.wd_window_ms = 9'(WD_WIN_BASE_MS + WD_WIN_STEP_MS * 9'(r6_reg[POS_WINDOW +: 5]));
        cfg_next.amp_offset_level = r7_reg[POS_OFFSET +: 4];
        cfg_next.amp_offset_mv = offset_mv_of(r7_reg[POS_OFFSET +: 4]);
        cfg_next.amp_offset_out = r7_reg[POS_OFFSET_OUT];
        cfg_next.amp_gain_select = r7_reg[POS_GAIN +: 3];
        cfg_next.amp_gain = gain_of(r7_reg[POS_GAIN +: 3]);
        cfg_next.turn_on_current_first = r8_reg[POS_FIRST +: 4];
        cfg_next.turn_on_current_second = r8_reg[POS_SECOND +: 4];
        cfg_next.turn_off_current_first = r9_reg[POS_FIRST +: 4];
        cfg_next.turn_off_current_second = r9_reg[POS_SECOND +: 4];
        cfg_next.turn_on_first_ua = current_ua(r8_reg[POS_FIRST +: 4], TURN_ON_STEP_UA);
        cfg_next.turn_on_second_ua = current_ua(r8_reg[POS_SECOND +: 4], TURN_ON_STEP_UA);
        cfg_next.turn_off_first_ua = current_ua(r9_reg[POS_FIRST +: 4], TURN_OFF_STEP_UA);
        cfg_next.turn_off_second_ua = current_ua(r9_reg[POS_SECOND +: 4], TURN_OFF_STEP_UA);
        // Bits 3..0: on first, on second, off first, off second
        cfg_next.switch_mode = {r8_reg[POS_FIRST +: 4] == 4'h0, r8_reg[POS_SECOND +: 4] == 4'h0,
            r9_reg[POS_FIRST +: 4] == 4'h0, r9_reg[POS_SECOND +: 4] == 4'h0};
        bemf_next = 1'b0;
        if (!r4_reg[POS_SELECTOR + 2]) begin
            unique case (mdcr_sel_t'(r4_reg[POS_SELECTOR +: 2]))
                MDCR_SEL_SPEED: bemf_next = cmp_s.speed_pulse_signal;
                MDCR_SEL_PHASE_A: bemf_next = cmp_s.phase_a;
                MDCR_SEL_PHASE_B: bemf_next = cmp_s.phase_b;
                MDCR_SEL_PHASE_C: bemf_next = cmp_s.phase_c;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_reg <= '0;
            bemf_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            bemf_reg <= bemf_next;
        end
    end

    assign cfg = cfg_reg;
    assign bemf_pin_out = bemf_reg;
    assign calibrate_start = cal_reg;
    assign frame_error = ferr_reg;
    assign sdo_o = sdo_reg;
    assign sdo_oe = sdo_oe_reg;
endmodule

// *** verification/mdcr_regs_asserts.sv ***
// Concurrent checks on the ports of the configuration register group
`timescale 1ns/1ps
module mdcr_regs_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Observed outputs
    input wire logic bemf_pin_out,
    input wire logic calibrate_start,
    input wire mdcr_pkg::mdcr_cfg_t cfg
);
    import mdcr_pkg::*;
    // ----------------
    // Settling counter
    // ----------------
    // Decoded settings read all zero just after reset, so wait for them
    logic [1:0] age_reg;
    logic [1:0] age_next;
    logic settled;
    always_comb begin
        age_next = srst ? 2'h0 : ((age_reg == 2'h3) ? age_reg : age_reg + 2'h1);
    end
    always_ff @(posedge mclk) begin
        age_reg <= age_next;
    end
    assign settled = (age_reg == 2'h3);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // ----------------
    // Properties
    // ----------------
    chk_sel_low_out: assert property (settled && cfg.bemf_pin_selector[2] && $past(cfg.bemf_pin_selector[2])
        |-> !bemf_pin_out) else $error("selector low code drives output high");
    chk_min_time_odd: assert property (settled |-> cfg.wd_min_ms[0] && cfg.wd_min_ms <= 8'h3f)
        else $error("minimum time off its grid");
    chk_window_grid: assert property (settled |-> cfg.wd_window_ms % 9'h00a == 9'h000
        && cfg.wd_window_ms inside {[9'h00a:9'h140]}) else $error("window time off its grid");
    chk_fail_disable: assert property (settled |-> cfg.wd_counter_enable == (cfg.watchdog_fail_count != 4'h0))
        else $error("fail counter enable wrong");
    chk_gain_map: assert property (settled |-> cfg.amp_gain == ((cfg.amp_gain_select == 3'h7) ? 6'h32
        : 6'h0a + 6'h05 * cfg.amp_gain_select)) else $error("gain decode wrong");
    chk_on_scale: assert property (settled |-> cfg.turn_on_first_ua == cfg.turn_on_current_first * 17'h0157c
        && cfg.turn_on_second_ua == cfg.turn_on_current_second * 17'h0157c) else $error("turn-on current wrong");
    chk_off_scale: assert property (settled |-> cfg.turn_off_first_ua == cfg.turn_off_current_first * 17'h014b4
        && cfg.turn_off_second_ua == cfg.turn_off_current_second * 17'h014b4) else $error("turn-off current wrong");
    chk_switch_mode: assert property (settled |-> cfg.switch_mode == {cfg.turn_on_current_first == 4'h0,
        cfg.turn_on_current_second == 4'h0, cfg.turn_off_current_first == 4'h0, cfg.turn_off_current_second == 4'h0})
        else $error("switch mode flags wrong");
    chk_cal_pulse: assert property (calibrate_start |=> !calibrate_start && !cfg.amp_offset_out)
        else $error("calibration start malformed");
    cov_cal: cover property (calibrate_start);
    cov_sel_low: cover property (settled && cfg.bemf_pin_selector[2]);
    cov_bemf_high: cover property ($rose(bemf_pin_out));
endmodule

bind mdcr_regs mdcr_regs_asserts u_chk (.mclk(mclk), .srst(srst), .bemf_pin_out(bemf_pin_out),
    .calibrate_start(calibrate_start), .cfg(cfg));

// *** verification/mdcr_host_model.sv ***
// Host controller model that shifts serial frames into the register group
`timescale 1ns/1ps
module mdcr_host_model (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic strobe_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    // ----------------
    // Frame transfer
    // ----------------
    initial begin
        strobe_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // Levels held 6 cycles so the input filter sees every edge; call at a falling edge
    task automatic xfer(input logic [15:0] f, input int n, output logic [15:0] rd);
        rd = 'x;
        strobe_n = 1'b0;
        sdi = f[15];
        repeat (6) @(negedge mclk);
        for (int i = 0; i < n; i++) begin
            sck = 1'b1;
            rd = {rd[14:0], sdo_oe ? sdo_o : 1'bx};
            repeat (6) @(negedge mclk);
            sck = 1'b0;
            if (i < 15) sdi = f[14 - i];
            repeat (6) @(negedge mclk);
        end
        strobe_n = 1'b1;
        // A released line never repeats its last bit
        sdi = ~sdi;
        repeat (10) @(negedge mclk);
    endtask
endmodule

// *** verification/tb_motor_driver_config_regs_4_to_9.sv ***
// Self-checking bench for the configuration register group
`timescale 1ns/1ps
module tb_motor_driver_config_regs_4_to_9;
    import mdcr_pkg::*;
    logic mclk, srst, strobe_n, sck, sdi, sdo_o, sdo_oe, bemf_pin_out, calibrate_start, frame_error;
    mdcr_cmp_t cmp_in;
    mdcr_cfg_t cfg;
    int mismatches = 0;
    int comparisons = 0;
    int cal_cnt = 0;
    int c0;
    logic [15:0] rd;
    logic [8:0] dflt [6] = '{9'h001, 9'h000, 9'h000, 9'h0c2, 9'h000, 9'h000};
    // Address, written data, read-back data, decoded value
    logic [39:0] rows [14] = '{{5'h04, 9'h1ff, 9'h07f, 17'h04e20}, {5'h04, 9'h018, 9'h018, 17'h01388},
        {5'h04, 9'h000, 9'h000, 17'h00000}, {5'h05, 9'h1ff, 9'h01f, 17'h0003f}, {5'h05, 9'h00a, 9'h00a, 17'h00015},
        {5'h06, 9'h1ff, 9'h1ff, 17'h00140}, {5'h06, 9'h00a, 9'h00a, 17'h0006e}, {5'h07, 9'h0f0, 9'h0f0, 17'h009c4},
        {5'h07, 9'h08f, 9'h08f, 17'h002ee}, {5'h07, 9'h0c2, 9'h0c2, 17'h00672}, {5'h08, 9'h1f0, 9'h0f0, 17'h14244},
        {5'h08, 9'h08f, 9'h08f, 17'h0abe0}, {5'h09, 9'h0c3, 9'h0c3, 17'h0f870}, {5'h09, 9'h0ff, 9'h0ff, 17'h1368c}};

    mdcr_regs u_dut (.mclk(mclk), .srst(srst), .strobe_n(strobe_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .cmp_in(cmp_in), .bemf_pin_out(bemf_pin_out), .calibrate_start(calibrate_start),
        .frame_error(frame_error), .cfg(cfg));
    mdcr_host_model u_host (.mclk(mclk), .strobe_n(strobe_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

    // ----------------
    // Helpers
    // ----------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (calibrate_start === 1'b1) cal_cnt++;
    end
    function automatic logic [15:0] mk(input logic [4:0] a, input logic w, input logic [8:0] d);
        return {a, w, d, ~^{a, w, d}};
    endfunction
    function automatic logic [16:0] pick(input logic [4:0] a);
        case (a)
            5'h04: return 17'(cfg.filter_us);
            5'h05: return 17'(cfg.wd_min_ms);
            5'h06: return 17'(cfg.wd_window_ms);
            5'h07: return 17'(cfg.amp_offset_mv);
            5'h08: return cfg.turn_on_first_ua;
            default: return cfg.turn_off_first_ua;
        endcase
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [4:0] a, input logic w, input logic [8:0] d);
        u_host.xfer(mk(a, w, d), 16, rd);
    endtask
    task automatic do_reset();
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        repeat (6) @(negedge mclk);
    endtask
    task automatic check_defaults();
        check("filter_us", 32'h0c8, cfg.filter_us);
        check("wd_min_ms", 32'h001, cfg.wd_min_ms);
        check("wd_window_ms", 32'h00a, cfg.wd_window_ms);
        check("wd_counter_enable", 32'h0, cfg.wd_counter_enable);
        check("amp_offset_mv", 32'h672, cfg.amp_offset_mv);
        check("amp_gain", 32'h014, cfg.amp_gain);
        check("switch_mode", 32'h00f, cfg.switch_mode);
        send(5'h04, 1'b0, 9'h000);
        for (int a = 5; a <= 10; a++) begin
            send(5'(a), 1'b0, 9'h000);
            check("default readback", mk(5'(a - 1), 1'b0, dflt[a - 5]), rd);
        end
        $display("test defaults done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        summarize();
    end

    // ----------------
    // Sequence
    // ----------------
    initial begin
        srst = 1'b1;
        cmp_in = 4'h0;
        @(negedge mclk);
        do_reset();
        check_defaults();
        foreach (rows[i]) begin
            send(rows[i][39:35], 1'b1, rows[i][34:26]);
            check("decoded value", rows[i][16:0], pick(rows[i][39:35]));
            send(rows[i][39:35], 1'b0, 9'h000);
            check("readback", mk(rows[i][39:35], 1'b0, rows[i][25:17]), rd);
        end
        // Table leaves gate registers at 08f and 0ff, so both second currents are code 15
        send(5'h06, 1'b1, 9'h140);
        check("watchdog_fail_count", 32'h00a, cfg.watchdog_fail_count);
        check("wd_counter_enable", 32'h1, cfg.wd_counter_enable);
        check("wd_window_ms", 32'h00a, cfg.wd_window_ms);
        check("turn_on_second_ua", 32'h14244, cfg.turn_on_second_ua);
        check("turn_off_second_ua", 32'h1368c, cfg.turn_off_second_ua);
        check("switch_mode", 32'h000, cfg.switch_mode);
        $display("test table done");
        for (int s = 0; s < 8; s++) begin
            send(5'h04, 1'b1, 9'(s << 4));
            for (int k = 0; k < 2; k++) begin
                cmp_in = k ? ~(4'h8 >> s[1:0]) : (4'h8 >> s[1:0]);
                repeat (10) @(negedge mclk);
                check("bemf_pin_out", (s < 4 && k == 0), bemf_pin_out);
            end
        end
        $display("test selector done");
        send(5'h07, 1'b1, 9'h0c2);
        c0 = cal_cnt;
        send(5'h07, 1'b1, 9'h1c2);
        check("calibration pulses", c0 + 1, cal_cnt);
        send(5'h07, 1'b1, 9'h1c2);
        send(5'h07, 1'b1, 9'h0c2);
        send(5'h07, 1'b1, 9'h1ca);
        check("calibration pulses", c0 + 1, cal_cnt);
        check("amp_offset_out", 32'h1, cfg.amp_offset_out);
        $display("test calibrate done");
        send(5'h05, 1'b1, 9'h003);
        u_host.xfer(mk(5'h05, 1'b1, 9'h00f) ^ 16'h0001, 16, rd);
        check("frame_error", 32'h1, frame_error);
        check("wd_min_ms", 32'h007, cfg.wd_min_ms);
        // A good frame first, so the short frame has to raise the error itself
        send(5'h05, 1'b1, 9'h003);
        u_host.xfer(mk(5'h05, 1'b1, 9'h00f), 15, rd);
        check("frame_error", 32'h1, frame_error);
        send(5'h0a, 1'b1, 9'h1ff);
        check("frame_error", 32'h0, frame_error);
        send(5'h0a, 1'b0, 9'h000);
        check("unmapped readback", mk(5'h0a, 1'b0, 9'h000), rd);
        check("wd_min_ms", 32'h007, cfg.wd_min_ms);
        $display("test refusals done");
        do_reset();
        check_defaults();
        summarize();
    end
endmodule
